// file: design/urx_receiver.sv
// Serial receiver with four-byte FIFO, error flags and AXI4-Lite registers
// Assumes serial_rx_pin is asynchronous and a single system clock
`timescale 1ns/100ps
module urx_receiver (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_serial_rx_pin,
    output logic             o_rx_irq,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready
);
    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic [31:0]              ctrl_r;
    logic [15:0]              baud_r;
    logic                     aw_got_r;
    logic                     w_got_r;
    logic [7:0]               awaddr_r;
    logic [31:0]              wdata_r;
    logic [3:0]               wstrb_r;
    logic                     wr_do;
    logic                     rd_do;
    logic                     stat_seen_r;
    logic                     data_rd;
    logic                     seq_clr;
    logic [2:0]               count_r;
    localparam int            URX_DEPTH_M1 = urx_pkg::URX_FIFO_DEPTH - 1;
    urx_pkg::urx_entry_t      fifo_r [URX_DEPTH_M1:0];
    logic [1:0]               rd_ptr_r;
    logic [1:0]               wr_ptr_r;
    logic                     ovr_r;
    logic                     noise_r;
    logic                     idle_r;
    logic [31:0]              status;
    logic [31:0]              rdata_mux;
    logic [1:0]               rresp_mux;

    assign o_awready = !aw_got_r && !o_bvalid;
    assign o_wready  = !w_got_r && !o_bvalid;
    assign wr_do     = aw_got_r && w_got_r && !o_bvalid;
    assign o_arready = !o_rvalid;
    assign rd_do     = i_arvalid && !o_rvalid;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp  <= urx_pkg::URX_RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= i_wdata;
                wstrb_r <= i_wstrb;
            end
            if (wr_do) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp  <= (awaddr_r == urx_pkg::URX_ADDR_CTRL || awaddr_r == urx_pkg::URX_ADDR_BAUD)
                            ? urx_pkg::URX_RESP_OKAY : urx_pkg::URX_RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= urx_pkg::URX_CTRL_RST;
            baud_r <= urx_pkg::URX_BAUD_RST;
        end else if (wr_do) begin
            if (awaddr_r == urx_pkg::URX_ADDR_CTRL) begin
                if (wstrb_r[0]) ctrl_r[7:0] <= wdata_r[7:0];
                if (wstrb_r[1]) ctrl_r[9:8] <= wdata_r[9:8];
            end
            if (awaddr_r == urx_pkg::URX_ADDR_BAUD) begin
                if (wstrb_r[0]) baud_r[7:0]  <= wdata_r[7:0];
                if (wstrb_r[1]) baud_r[15:8] <= wdata_r[15:8];
            end
        end
    end

    always_comb begin
        status = 32'h0000_0000;
        status[urx_pkg::URX_S_AVAIL] = (count_r != 3'h0);
        status[urx_pkg::URX_S_OVR]   = ovr_r;
        status[urx_pkg::URX_S_NOISE] = noise_r;
        status[urx_pkg::URX_S_FRAME] = (count_r != 3'h0) && fifo_r[rd_ptr_r].frame;
        status[urx_pkg::URX_S_PAR]   = (count_r != 3'h0) && fifo_r[rd_ptr_r].parity;
        status[urx_pkg::URX_S_IDLE]  = idle_r;
    end

    always_comb begin
        rdata_mux = 32'h0000_0000;
        rresp_mux = urx_pkg::URX_RESP_OKAY;
        case (i_araddr)
            urx_pkg::URX_ADDR_CTRL: begin
                rdata_mux = ctrl_r;
                rdata_mux[urx_pkg::URX_C_BIT9] = fifo_r[rd_ptr_r].bit9;
            end
            urx_pkg::URX_ADDR_BAUD:   rdata_mux = {16'h0000, baud_r};
            urx_pkg::URX_ADDR_STATUS: rdata_mux = status;
            urx_pkg::URX_ADDR_DATA:   rdata_mux = {24'h00_0000, fifo_r[rd_ptr_r].data};
            urx_pkg::URX_ADDR_COUNT:  rdata_mux = {29'h0000_0000, count_r};
            default:                  rresp_mux = urx_pkg::URX_RESP_SLVERR;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= urx_pkg::URX_RESP_OKAY;
        end else if (rd_do) begin
            o_rvalid <= 1'b1;
            o_rdata  <= rdata_mux;
            o_rresp  <= rresp_mux;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Status-then-data clear sequence
    // ****************************************************************
    assign data_rd = rd_do && i_araddr == urx_pkg::URX_ADDR_DATA;
    assign seq_clr = data_rd && stat_seen_r;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stat_seen_r <= 1'b0;
        end else if (rd_do && i_araddr == urx_pkg::URX_ADDR_STATUS) begin
            stat_seen_r <= 1'b1;
        end else if (data_rd) begin
            stat_seen_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Line sampling and baud tick
    // ****************************************************************
    logic        rx_s1_r;
    logic        rx_s2_r;
    logic [15:0] div_cnt_r;
    logic        tick;
    logic [3:0]  os_cnt_r;
    logic [2:0]  vote_r;
    logic        bit_val;
    logic        bit_noisy;
    logic        rx_en;
    logic        nine;

    assign rx_en = ctrl_r[urx_pkg::URX_C_EN];
    assign nine  = ctrl_r[urx_pkg::URX_C_NINE];
    assign tick  = (div_cnt_r == 16'h0000);

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end else begin
            rx_s1_r <= i_serial_rx_pin;
            rx_s2_r <= rx_s1_r;
        end
    end

    // Oversample tick at sixteen per bit, period baud_r plus one
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_cnt_r <= 16'h0000;
        end else if (tick || !rx_en) begin
            div_cnt_r <= baud_r;
        end else begin
            div_cnt_r <= div_cnt_r - 16'h0001;
        end
    end

    // Majority of samples 7, 8 and 9
    assign bit_val   = (vote_r[0] & vote_r[1]) | (vote_r[1] & vote_r[2]) | (vote_r[0] & vote_r[2]);
    assign bit_noisy = !(vote_r == 3'h0 || vote_r == 3'h7);

    // ****************************************************************
    // Frame state machine
    // ****************************************************************
    urx_pkg::urx_state_t state_r;
    logic [3:0]          bit_idx_r;
    logic [9:0]          shift_r;
    logic                noise_frm_r;
    logic                frame_end;
    logic [3:0]          last_idx;
    logic                par_en;
    logic [1:0]          par_typ;
    logic                par_bad;
    logic                push;
    logic                push_ok;
    logic                fifo_pop;
    logic                overrun;
    logic [3:0]          word_bits;
    logic [8:0]          word;
    urx_pkg::urx_entry_t new_entry;

    assign par_en   = ctrl_r[urx_pkg::URX_C_PEN];
    assign par_typ  = ctrl_r[urx_pkg::URX_C_PTYP +: 2];
    assign word_bits = nine ? 4'h9 : 4'h8;
    // Data bits (8 or 9, parity included) then stop bit(s)
    assign last_idx  = word_bits + {3'h0, ctrl_r[urx_pkg::URX_C_STOP2]};
    // Ends on the last stop bit, or early on any low stop bit
    assign frame_end = state_r == urx_pkg::URX_SHIFT && tick && os_cnt_r == 4'hf
                       && (bit_idx_r == last_idx || (!bit_val && bit_idx_r >= word_bits));

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r     <= urx_pkg::URX_IDLE;
            os_cnt_r    <= 4'h0;
            bit_idx_r   <= 4'h0;
            shift_r     <= 10'h000;
            vote_r      <= 3'h0;
            noise_frm_r <= 1'b0;
        end else if (!rx_en) begin
            state_r <= urx_pkg::URX_IDLE;
        end else if (tick) begin
            os_cnt_r <= os_cnt_r + 4'h1;
            if (os_cnt_r >= 4'h7 && os_cnt_r <= 4'h9) begin
                vote_r <= {vote_r[1:0], rx_s2_r};
            end
            case (state_r)
                urx_pkg::URX_IDLE: begin
                    os_cnt_r <= 4'h0;
                    if (!rx_s2_r) begin
                        state_r     <= urx_pkg::URX_START;
                        os_cnt_r    <= 4'h1;
                        noise_frm_r <= 1'b0;
                    end
                end
                urx_pkg::URX_START: begin
                    if (os_cnt_r == 4'hf) begin
                        if (bit_val) begin
                            state_r <= urx_pkg::URX_IDLE;
                        end else begin
                            state_r   <= urx_pkg::URX_SHIFT;
                            bit_idx_r <= 4'h0;
                        end
                        noise_frm_r <= bit_noisy;
                    end
                end
                urx_pkg::URX_SHIFT: begin
                    if (os_cnt_r == 4'hf) begin
                        noise_frm_r <= noise_frm_r | bit_noisy;
                        bit_idx_r   <= bit_idx_r + 4'h1;
                        if (bit_idx_r < word_bits) begin
                            shift_r <= {bit_val, shift_r[9:1]};
                        end
                        if (frame_end) begin
                            state_r <= (bit_val ? urx_pkg::URX_IDLE : urx_pkg::URX_WAITH);
                        end
                    end
                end
                urx_pkg::URX_WAITH: begin
                    os_cnt_r <= 4'h0;
                    if (rx_s2_r) begin
                        state_r <= urx_pkg::URX_IDLE;
                    end
                end
                default: state_r <= urx_pkg::URX_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idle_r <= 1'b1;
        end else begin
            idle_r <= (state_r == urx_pkg::URX_IDLE) || (state_r == urx_pkg::URX_WAITH);
        end
    end

    // ****************************************************************
    // Received word and FIFO
    // ****************************************************************
    assign word    = nine ? shift_r[9:1] : {1'b0, shift_r[9:2]};
    assign par_bad = (par_typ == urx_pkg::URX_PAR_EVEN) ? (^word)
                   : (par_typ == urx_pkg::URX_PAR_ODD)  ? !(^word)
                   : (par_typ == urx_pkg::URX_PAR_MARK) ? !(nine ? word[8] : word[7])
                   : (nine ? word[8] : word[7]);

    always_comb begin
        new_entry        = '0;
        new_entry.data   = (par_en && !nine) ? {1'b0, word[6:0]} : word[7:0];
        new_entry.bit9   = nine && word[8];
        new_entry.frame  = !bit_val;
        new_entry.parity = par_en && par_bad;
    end

    assign push     = frame_end;
    assign fifo_pop = data_rd && (count_r != 3'h0);
    assign push_ok  = push && (count_r != 3'(urx_pkg::URX_FIFO_DEPTH) || fifo_pop);
    assign overrun  = push && !push_ok;

    for (genvar g = 0; g < urx_pkg::URX_FIFO_DEPTH; g++) begin : g_slot
        always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
            if (!i_rst_n) begin
                fifo_r[g] <= '0;
            end else if (push_ok && wr_ptr_r == 2'(g)) begin
                fifo_r[g] <= new_entry;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_ptr_r <= 2'h0;
            wr_ptr_r <= 2'h0;
            count_r  <= 3'h0;
        end else begin
            if (fifo_pop) rd_ptr_r <= rd_ptr_r + 2'h1;
            if (push_ok) wr_ptr_r <= wr_ptr_r + 2'h1;
            count_r <= count_r + {2'h0, push_ok} - {2'h0, fifo_pop};
        end
    end

    // Sticky flags; a new event beats the clearing read
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ovr_r <= 1'b0;
        end else if (overrun) begin
            ovr_r <= 1'b1;
        end else if (seq_clr) begin
            ovr_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            noise_r <= 1'b0;
        end else if (push_ok && (noise_frm_r || bit_noisy)) begin
            noise_r <= 1'b1;
        end else if (seq_clr) begin
            noise_r <= 1'b0;
        end
    end

    // One-cycle request on reaching trigger level or on overrun
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_irq <= 1'b0;
        end else begin
            o_rx_irq <= ctrl_r[urx_pkg::URX_C_RIE]
                        && ((push_ok && count_r >= {1'b0, ctrl_r[urx_pkg::URX_C_TRIG +: 2]}) || overrun);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_count_max;
        @(posedge i_clk_sys) disable iff (!i_rst_n) count_r <= 3'(urx_pkg::URX_FIFO_DEPTH);
    endproperty
    a_count_max: assert property (p_count_max) else $error("fifo count above depth");

    property p_ovr_keep;
        @(posedge i_clk_sys) disable iff (!i_rst_n) overrun |=> ovr_r && count_r == 3'h4;
    endproperty
    a_ovr_keep: assert property (p_ovr_keep) else $error("overrun lost flag or data");

    property p_ovr_irq;
        @(posedge i_clk_sys) disable iff (!i_rst_n) (overrun && ctrl_r[urx_pkg::URX_C_RIE]) |=> o_rx_irq;
    endproperty
    a_ovr_irq: assert property (p_ovr_irq) else $error("overrun without interrupt");

    property p_ovr_hold;
        @(posedge i_clk_sys) disable iff (!i_rst_n) (ovr_r && !seq_clr) |=> ovr_r;
    endproperty
    a_ovr_hold: assert property (p_ovr_hold) else $error("overrun cleared without sequence");

    property p_noise_set;
        @(posedge i_clk_sys) disable iff (!i_rst_n) (push_ok && bit_noisy) |=> noise_r;
    endproperty
    a_noise_set: assert property (p_noise_set) else $error("noise flag not set");

    property p_busy_idle;
        @(posedge i_clk_sys) disable iff (!i_rst_n) state_r == urx_pkg::URX_SHIFT |=> !idle_r;
    endproperty
    a_busy_idle: assert property (p_busy_idle) else $error("idle high while shifting");

    property p_break_wait;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
            (state_r == urx_pkg::URX_WAITH && !rx_s2_r && rx_en) |=> state_r == urx_pkg::URX_WAITH;
    endproperty
    a_break_wait: assert property (p_break_wait) else $error("left break wait on low line");
endmodule

// file: inc/urx_pkg.sv
// Constants and types for the serial receiver with four-byte FIFO
// Assumes a 40 MHz system clock and an AXI4-Lite master on the register side
// Behaviour
// - Serial characters shift in from the receive pin, least significant bit first.
// - Receive data is a four-byte FIFO; a fifth byte assembles in the shifter.
// - Byte finishing while FIFO full is dropped, FIFO kept, overrun flag set.
// - Overrun requests receive interrupt when receive interrupt enable is set.
// - Setting receiver enable makes the receiver hunt for a start bit.
// - Data-available flag follows FIFO non-empty; byte count is readable.
// - FIFO fill reaching trigger level with enable set requests an interrupt.
// - Data-available clears when a data read empties the FIFO; no status access needed.
// - Overrun clears only by status access followed by data read.
// - Noise sets noise flag with data-available, data still stored, no own interrupt.
// - Noise flag clears by status read followed by data read.
// - Low stop bit sets framing error; with two stop bits both must be high.
// - Break ends after data bits plus one stop; zero char, framing, idle set.
// - After break no new start bit until line seen high.
// - Idle flag rises during break before stop bits arrive.
// - Idle low from start detect to stop bit, high otherwise.
// - With parity enabled, odd, even, mark or space check failure sets parity error.
// - Framing and parity errors stored with their data word; cleared by reset.
// - Recovery runs at sixteen times baud with three-sample majority vote.
// - Ninth received bit goes to a dedicated control field, not the data byte.
package urx_pkg;
    localparam logic [7:0]  URX_ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  URX_ADDR_BAUD   = 8'h04;
    localparam logic [7:0]  URX_ADDR_STATUS = 8'h08;
    localparam logic [7:0]  URX_ADDR_DATA   = 8'h0c;
    localparam logic [7:0]  URX_ADDR_COUNT  = 8'h10;
    // Control fields
    localparam int          URX_C_EN        = 0;
    localparam int          URX_C_NINE      = 1;
    localparam int          URX_C_PEN       = 2;
    localparam int          URX_C_PTYP      = 3;  // 2 bits
    localparam int          URX_C_STOP2     = 5;
    localparam int          URX_C_RIE       = 6;
    localparam int          URX_C_TRIG      = 8;  // 2 bits, level minus one
    localparam int          URX_C_BIT9      = 10; // Read-only ninth bit
    // Status fields
    localparam int          URX_S_AVAIL     = 0;
    localparam int          URX_S_OVR       = 1;
    localparam int          URX_S_NOISE     = 2;
    localparam int          URX_S_FRAME     = 3;
    localparam int          URX_S_PAR       = 4;
    localparam int          URX_S_IDLE      = 5;
    localparam logic [31:0] URX_CTRL_RST    = 32'h0000_0000;
    localparam logic [15:0] URX_BAUD_RST    = 16'h0000;
    localparam int          URX_OVERSAMPLE  = 16;
    localparam int          URX_FIFO_DEPTH  = 4;
    localparam int          URX_BREAK_BITS  = 13;
    localparam logic [1:0]  URX_PAR_EVEN    = 2'h0;
    localparam logic [1:0]  URX_PAR_ODD     = 2'h1;
    localparam logic [1:0]  URX_PAR_MARK    = 2'h2;
    localparam logic [1:0]  URX_PAR_SPACE   = 2'h3;
    localparam logic [1:0]  URX_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  URX_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       bit9;
        logic       frame;
        logic       parity;
        logic [7:0] data;
    } urx_entry_t;

    typedef enum logic [3:0] {
        URX_IDLE  = 4'b0001,
        URX_START = 4'b0010,
        URX_SHIFT = 4'b0100,
        URX_WAITH = 4'b1000
    } urx_state_t;
endpackage

// file: test/test_uart_receiver_fifo_errors.sv
// Self-checking bench for the serial receiver and its register bus
// Assumes urx_pkg compiled first and the transmitter model beside it
`timescale 1ns/100ps
module test_uart_receiver_fifo_errors;
    localparam int         BIT  = 64; // Divisor 3: (3+1)*16 clocks a bit
    localparam logic [7:0] A_ST = urx_pkg::URX_ADDR_STATUS;
    localparam logic [7:0] A_DT = urx_pkg::URX_ADDR_DATA;
    localparam logic [7:0] A_CN = urx_pkg::URX_ADDR_COUNT;
    localparam logic [7:0] A_CT = urx_pkg::URX_ADDR_CTRL;
    logic        clk, rst_n, line, irq, irq_seen, pb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r, pt;
    logic [8:0]  pat [4];
    int          failures, check_count, cyc, i, b;

    urx_receiver dut_u (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_serial_rx_pin(line), .o_rx_irq(irq),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready)
    );
    urx_serial_tx #(.BIT_CLKS(BIT)) tx_u (.i_clk(clk), .o_line(line));

    // ****************************************
    // Bus tasks and comparisons
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("Checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ar;
        ar = 1'b1;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (ar && arready === 1'b1) begin
                ar = 1'b0;
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1) break;
        end
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic sbit(input int p, input logic e);
        rd(A_ST, d, r);
        chk(32'(d[p]), 32'(e));
    endtask
    task automatic pop(input logic [7:0] e, input logic fe, input logic pe);
        rd(A_ST, d, r);
        chk(32'(d[urx_pkg::URX_S_FRAME]), 32'(fe));
        chk(32'(d[urx_pkg::URX_S_PAR]), 32'(pe));
        rd(A_DT, d, r);
        chk(32'(d[7:0]), 32'(e));
    endtask
    function automatic logic [31:0] cfg(input logic n, input logic pe, input logic [1:0] p,
                                        input logic s2, input logic [1:0] tg);
        cfg = (32'h1 << urx_pkg::URX_C_EN) | (32'h1 << urx_pkg::URX_C_RIE)
            | (32'(n) << urx_pkg::URX_C_NINE) | (32'(pe) << urx_pkg::URX_C_PEN)
            | (32'(p) << urx_pkg::URX_C_PTYP) | (32'(s2) << urx_pkg::URX_C_STOP2)
            | (32'(tg) << urx_pkg::URX_C_TRIG);
    endfunction

    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) irq_seen <= 1'b1;
        if (cyc == 60000) begin
            failures++;
            finish_test();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, irq_seen} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {failures, check_count, cyc} = '0;
        pat = '{9'h0a5, 9'h03c, 9'h081, 9'h07e};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        wstrb <= 4'hf;
        @(posedge clk);
        rd(A_CT, d, r);
        chk(d, urx_pkg::URX_CTRL_RST);
        rd(A_CN, d, r);
        chk(d, 32'h0);
        rd(8'h14, d, r);
        chk(32'(r), 32'(urx_pkg::URX_RESP_SLVERR));
        wr(urx_pkg::URX_ADDR_BAUD, 32'h3);
        wr(A_CT, cfg(1'b0, 1'b0, 2'h0, 1'b0, 2'h3));
        for (i = 0; i < 3; i++) tx_u.send(pat[i], 8, 1'b0, 1'b0, 2'h3, 1, 1'b0);
        chk(32'(irq_seen), 32'h0);
        tx_u.send(pat[3], 8, 1'b0, 1'b0, 2'h3, 1, 1'b0);
        chk(32'(irq_seen), 32'h1);
        rd(A_CN, d, r);
        chk(d, 32'h4);
        sbit(urx_pkg::URX_S_AVAIL, 1'b1);
        irq_seen <= 1'b0;
        tx_u.send(9'h05a, 8, 1'b0, 1'b0, 2'h3, 1, 1'b0);
        chk(32'(irq_seen), 32'h1);
        sbit(urx_pkg::URX_S_OVR, 1'b1);
        rd(A_CN, d, r);
        chk(d, 32'h4);
        sbit(urx_pkg::URX_S_OVR, 1'b1);
        for (i = 0; i < 4; i++) begin
            pop(pat[i][7:0], 1'b0, 1'b0);
            sbit(urx_pkg::URX_S_OVR, 1'b0);
            sbit(urx_pkg::URX_S_AVAIL, i < 3);
        end
        for (b = 0; b < 8; b++) begin
            pt = b[2:1];
            wr(A_CT, cfg(1'b0, 1'b1, pt, 1'b0, 2'h0));
            pb = (pt == urx_pkg::URX_PAR_ODD) ? ~^7'h35 : (pt == urx_pkg::URX_PAR_EVEN) ? ^7'h35
               : (pt == urx_pkg::URX_PAR_MARK);
            tx_u.send(9'h035, 7, 1'b1, pb ^ b[0], 2'h3, 1, 1'b0);
            pop(8'h35, 1'b0, b[0]);
        end
        wr(A_CT, cfg(1'b0, 1'b0, 2'h0, 1'b0, 2'h0));
        tx_u.send(9'h042, 8, 1'b0, 1'b0, 2'h0, 1, 1'b0);
        pop(8'h42, 1'b1, 1'b0);
        wr(A_CT, cfg(1'b0, 1'b0, 2'h0, 1'b1, 2'h0));
        tx_u.send(9'h024, 8, 1'b0, 1'b0, 2'h1, 2, 1'b0);
        pop(8'h24, 1'b1, 1'b0);
        tx_u.send(9'h018, 8, 1'b0, 1'b0, 2'h3, 2, 1'b0);
        pop(8'h18, 1'b0, 1'b0);
        wr(A_CT, cfg(1'b0, 1'b0, 2'h0, 1'b0, 2'h0));
        tx_u.send(9'h069, 8, 1'b0, 1'b0, 2'h3, 1, 1'b1);
        sbit(urx_pkg::URX_S_NOISE, 1'b1);
        rd(A_DT, d, r);
        chk(32'(d[7:0]), 32'h69);
        sbit(urx_pkg::URX_S_NOISE, 1'b0);
        wr(A_CT, cfg(1'b1, 1'b0, 2'h0, 1'b0, 2'h0));
        tx_u.send(9'h1c3, 9, 1'b0, 1'b0, 2'h3, 1, 1'b0);
        rd(A_ST, d, r);
        rd(A_CT, d, r);
        chk(32'(d[urx_pkg::URX_C_BIT9]), 32'h1);
        rd(A_DT, d, r);
        chk(32'(d[7:0]), 32'hc3);
        wr(A_CT, cfg(1'b0, 1'b0, 2'h0, 1'b0, 2'h0));
        fork
            tx_u.brk(20);
            begin
                repeat (14 * BIT) @(posedge clk);
                sbit(urx_pkg::URX_S_IDLE, 1'b1);
            end
        join
        rd(A_CN, d, r);
        chk(d, 32'h1);
        pop(8'h00, 1'b1, 1'b0);
        fork
            tx_u.send(9'h033, 8, 1'b0, 1'b0, 2'h3, 1, 1'b0);
            begin
                repeat (5 * BIT) @(posedge clk);
                sbit(urx_pkg::URX_S_IDLE, 1'b0);
            end
        join
        sbit(urx_pkg::URX_S_IDLE, 1'b1);
        pop(8'h33, 1'b0, 1'b0);
        finish_test();
    end
endmodule

// file: test/urx_serial_tx.sv
// Model of the remote serial transmitter driving the receive pin
// Assumes bench clock edges; the line idles high outside frames
`timescale 1ns/100ps
module urx_serial_tx #(
    parameter int BIT_CLKS = 64
) (
    input  wire logic i_clk,
    output logic      o_line
);
    initial o_line = 1'b1;
    task automatic hold(input logic v, input int n);
        o_line <= v;
        repeat (n) @(posedge i_clk);
    endtask
    // ****************************************
    // Frame: start, data, parity, stops, idle
    // ****************************************
    task automatic send(input logic [8:0] v, input int nb, input logic pe, input logic pb,
                        input logic [1:0] sv, input int ns, input logic nz);
        int k;
        hold(1'b0, BIT_CLKS);
        for (k = 0; k < nb; k++) begin
            if (nz && k == 0) begin
                // One-tick glitch at the bit centre
                hold(v[k], BIT_CLKS / 2 - 2);
                hold(~v[k], 4);
                hold(v[k], BIT_CLKS / 2 - 2);
            end else begin
                hold(v[k], BIT_CLKS);
            end
        end
        if (pe) hold(pb, BIT_CLKS);
        for (k = 0; k < ns; k++) hold(sv[k], BIT_CLKS);
        hold(1'b1, BIT_CLKS);
    endtask
    task automatic brk(input int nbits);
        hold(1'b0, nbits * BIT_CLKS);
        hold(1'b1, 2 * BIT_CLKS);
    endtask
endmodule
